// File: core/standby_conversion_control.v
`timescale 1ns/10ps
`default_nettype none
`include "standby_ctrl_defs.vh"

module standby_conversion_control #(
  // Half of one conversion cycle, in clock cycles
  parameter [`HALF_CNT_W-1:0] HALF_CYCLES = `HALF_CONV_CYCLES
) (
  // Clock and reset
  input wire clk,
  input wire sys_rst,

  // Wishbone slave
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,

  // Device pins
  input wire standbyPinN,
  input wire addrSelect0,
  input wire addrSelect1,
  input wire overtempOutI,
  output reg overtempOutO,
  output reg overtempOutOe,

  // Converter front end
  input wire [7:0] remoteSample,
  input wire [7:0] localSample,
  output reg adcEnable,
  output reg adcChannel
);

  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_REMOTE = 2'd1;
  localparam [1:0] ST_LOCAL = 2'd2;

  // Pin synchronisers
  reg [3:0] pinMeta_reg;
  reg [3:0] pinSync_reg;

  // Software visible state
  reg [7:0] config_reg;
  reg [7:0] rate_reg;
  reg [7:0] trip_reg;
  reg [7:0] release_reg;
  reg [7:0] remote_reg;
  reg [7:0] local_reg;
  reg [7:0] remotePend_reg;
  reg oneShotPend_reg;
  reg [1:0] addrLatch_reg;
  reg [1:0] capCount_reg;

  // Sequencer
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg otActive_reg;
  reg otActive_next;

  wire hwStandby;
  wire haltBit;
  wire standbyReq;
  wire busWrite;
  wire busAccess;
  wire haltWrite;
  wire abortConv;
  wire startAuto;
  wire startOneShot;
  wire startConv;
  wire convDone;
  wire halfTick;
  wire gapZero;
  wire busy;
  wire [7:0] statusWord;
  reg [7:0] readWord;

  always @(posedge clk) begin
    if (sys_rst) begin
      pinMeta_reg <= 4'h0;
      pinSync_reg <= 4'h0;
    end else begin
      pinMeta_reg <= {overtempOutI, addrSelect1, addrSelect0, standbyPinN};
      pinSync_reg <= pinMeta_reg;
    end
  end

  // Reset value of the sync is low, so the block starts in standby
  // until the pin has been seen high for two cycles.
  assign hwStandby = ~pinSync_reg[0]; // RULE_12
  assign haltBit = config_reg[`CFG_HALT_BIT];
  assign standbyReq = hwStandby | haltBit; // RULE_02

  // Wishbone request decode
  assign busAccess = cyc_i & stb_i & ~ack_o;
  assign busWrite = cyc_i & stb_i & ack_o & we_i & sel_i[0];
  assign haltWrite = busWrite && (adr_i == `OFS_CONFIG) &&
    dat_i[`CFG_HALT_BIT];

  assign busy = (state_reg != ST_IDLE);

  // A halt written during any conversion aborts it, even a one-shot
  assign abortConv = busy & (hwStandby | haltWrite); // RULE_07
  assign startOneShot = oneShotPend_reg & ~hwStandby; // RULE_04 RULE_05
  assign startAuto = ~standbyReq & gapZero; // RULE_01 RULE_16
  assign startConv = (state_reg == ST_IDLE) & ~hwStandby &
    (startOneShot | startAuto); // RULE_06
  assign convDone = (state_reg == ST_LOCAL) & halfTick & ~abortConv;

  // Half-conversion tick, restarted by each start
  interval_counter #(
    .W(`HALF_CNT_W)
  ) halfTimer (
    .clk(clk),
    .sys_rst(sys_rst),
    .load(startConv | halfTick),
    .loadValue(HALF_CYCLES - {{(`HALF_CNT_W-1){1'b0}}, 1'b1}),
    .dec(1'b1),
    .zero(halfTick)
  );

  // Spacing between automatic cycles, in half-conversion ticks
  interval_counter #(
    .W(`GAP_CNT_W)
  ) gapTimer (
    .clk(clk),
    .sys_rst(sys_rst),
    .load(convDone),
    .loadValue({rate_reg, 1'b0}),
    .dec(halfTick),
    .zero(gapZero)
  ); // RULE_11

  // Conversion sequencer
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (startConv) begin
          state_next = ST_REMOTE; // RULE_15
        end
      end
      ST_REMOTE: begin
        if (abortConv) begin
          state_next = ST_IDLE; // RULE_07
        end else if (halfTick) begin
          state_next = ST_LOCAL; // RULE_15
        end
      end
      ST_LOCAL: begin
        if (abortConv || halfTick) begin
          state_next = ST_IDLE; // RULE_11
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      adcEnable <= 1'b0;
      adcChannel <= 1'b0;
    end else begin
      state_reg <= state_next;
      adcEnable <= (state_next != ST_IDLE); // RULE_01
      adcChannel <= (state_next == ST_LOCAL);
    end
  end

  // Results: remote is held aside until local completes the cycle
  always @(posedge clk) begin
    if (sys_rst) begin
      remotePend_reg <= `RST_RESULT;
      remote_reg <= `RST_RESULT;
      local_reg <= `RST_RESULT;
    end else begin
      if ((state_reg == ST_REMOTE) && halfTick && !abortConv) begin
        remotePend_reg <= remoteSample;
      end
      if (convDone) begin
        remote_reg <= remotePend_reg; // RULE_15
        local_reg <= localSample; // RULE_08
      end
    end
  end

  // One-shot request; a new write wins over consumption
  always @(posedge clk) begin
    if (sys_rst) begin
      oneShotPend_reg <= 1'b0;
    end else if (busWrite && (adr_i == `OFS_ONESHOT)) begin
      oneShotPend_reg <= 1'b1;
    end else if (hwStandby) begin
      oneShotPend_reg <= 1'b0; // RULE_04
    end else if (startConv) begin
      oneShotPend_reg <= 1'b0;
    end
  end

  // Writable registers stay writable in either standby
  always @(posedge clk) begin
    if (sys_rst) begin
      config_reg <= `RST_CONFIG;
      rate_reg <= `RST_RATE;
      trip_reg <= `RST_TRIP;
      release_reg <= `RST_RELEASE;
    end else if (busWrite) begin // RULE_03
      case (adr_i)
        `OFS_CONFIG: begin
          config_reg <= dat_i[7:0];
        end
        `OFS_RATE: begin
          rate_reg <= dat_i[7:0];
        end
        `OFS_TRIP: begin
          trip_reg <= dat_i[7:0];
        end
        `OFS_RELEASE: begin
          release_reg <= dat_i[7:0];
        end
        default: begin
          config_reg <= config_reg;
        end
      endcase
    end
  end

  // Thermostat compare runs every cycle, so a limit write acts at
  // once against the last committed remote result, standby or not.
  always @* begin
    otActive_next = otActive_reg;
    if ($signed(remote_reg) > $signed(trip_reg)) begin
      otActive_next = 1'b1; // RULE_13
    end else if ($signed(remote_reg) < $signed(release_reg)) begin
      otActive_next = 1'b0; // RULE_13
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      otActive_reg <= 1'b0;
      overtempOutO <= 1'b0;
      overtempOutOe <= 1'b0;
    end else begin
      otActive_reg <= otActive_next; // RULE_09 RULE_10
      overtempOutO <= 1'b0;
      // Open drain: pulling low is the active level unless inverted
      overtempOutOe <= otActive_next ^
        config_reg[`CFG_POL_BIT]; // RULE_14
    end
  end

  // Address straps captured once the synchroniser has filled
  always @(posedge clk) begin
    if (sys_rst) begin
      capCount_reg <= 2'd0;
      addrLatch_reg <= 2'b00;
    end else if (capCount_reg != 2'd3) begin
      capCount_reg <= capCount_reg + 2'd1;
      if (capCount_reg == 2'd2) begin
        addrLatch_reg <= pinSync_reg[2:1];
      end
    end
  end

  assign statusWord = {
    oneShotPend_reg,
    pinSync_reg[3],
    addrLatch_reg,
    haltBit,
    hwStandby,
    otActive_reg,
    busy
  };

  always @* begin
    case (adr_i)
      `OFS_CONFIG: readWord = config_reg;
      `OFS_RATE: readWord = rate_reg;
      `OFS_TRIP: readWord = trip_reg;
      `OFS_RELEASE: readWord = release_reg;
      `OFS_REMOTE: readWord = remote_reg; // RULE_08
      `OFS_LOCAL: readWord = local_reg;
      `OFS_STATUS: readWord = statusWord;
      default: readWord = 8'h00;
    endcase
  end

  // Single-wait-state slave; unmapped reads return zero with ack
  always @(posedge clk) begin
    if (sys_rst) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      ack_o <= busAccess;
      if (busAccess && !we_i) begin
        dat_o <= {24'h000000, readWord};
      end
    end
  end

endmodule // standby_conversion_control

`default_nettype wire

// File: pkg/standby_ctrl_defs.vh
// Notes on behaviour
// (RULE_01) Standby keeps converter off, no auto starts
// (RULE_02) Standby from low pin or halt bit
// (RULE_03) Standby keeps registers and bus access alive
// (RULE_04) Hardware standby ignores the one-shot command
// (RULE_05) Software standby one-shot converts both channels once
// (RULE_06) Low standby pin beats every software start
// (RULE_07) Standby during conversion aborts, no result write
// (RULE_08) Aborted conversion leaves both results unchanged
// (RULE_09) Over-temperature output keeps working in standby
// (RULE_10) New limits compared at once with last result
// (RULE_11) Conversion lasts 125ms; rate timer spaces auto cycles
// (RULE_12) Pin low means standby, high means operate
// (RULE_13) Trip above trip limit, release below release limit
// (RULE_14) Output active low; config bit 5 inverts
// (RULE_15) Every start converts remote then local channel
// (RULE_16) Leaving standby resumes auto conversions unaided
`ifndef STANDBY_CTRL_DEFS_VH
`define STANDBY_CTRL_DEFS_VH

// Register byte offsets
`define OFS_CONFIG 8'h00
`define OFS_RATE 8'h04
`define OFS_ONESHOT 8'h08
`define OFS_TRIP 8'h0c
`define OFS_RELEASE 8'h10
`define OFS_REMOTE 8'h14
`define OFS_LOCAL 8'h18
`define OFS_STATUS 8'h1c

// Configuration fields
`define CFG_POL_BIT 5
`define CFG_HALT_BIT 6

// Status fields
`define ST_BUSY_BIT 0
`define ST_OT_BIT 1
`define ST_HWSTBY_BIT 2
`define ST_HALT_BIT 3
`define ST_ADDR0_BIT 4
`define ST_ADDR1_BIT 5
`define ST_OTPIN_BIT 6
`define ST_PEND_BIT 7

// Reset values
`define RST_CONFIG 8'h00
`define RST_RATE 8'h00
`define RST_TRIP 8'h64
`define RST_RELEASE 8'h5f
`define RST_RESULT 8'h00

// Timing
`define CONV_TIME_MS 125
`define CLK_KHZ 100000
// Half of one 125 ms conversion at 100 MHz
`define HALF_CONV_CYCLES 24'h5f5e10
`define HALF_CNT_W 24
`define GAP_CNT_W 9

`endif

// File: core/interval_counter.v
`timescale 1ns/10ps
`default_nettype none

module interval_counter #(
  parameter W = 8
) (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Control
  input wire load,
  input wire [W-1:0] loadValue,
  input wire dec,
  // Status
  output wire zero
);

  reg [W-1:0] count_reg;

  always @(posedge clk) begin
    if (sys_rst) begin
      count_reg <= {W{1'b0}};
    end else if (load) begin
      count_reg <= loadValue;
    end else if (dec && (count_reg != {W{1'b0}})) begin
      count_reg <= count_reg - {{(W-1){1'b0}}, 1'b1};
    end
  end

  assign zero = (count_reg == {W{1'b0}});

endmodule // interval_counter

`default_nettype wire

// File: verif/standby_props.sv
`timescale 1ns/10ps
`default_nettype none
module standby_props #(
  parameter int HALF_CYCLES = 6250000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Bus
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // Pins and converter
  input wire logic standbyPinN,
  input wire logic overtempOutO,
  input wire logic adcEnable,
  input wire logic adcChannel
);
  int convCnt;
  always @(posedge clk) begin
    convCnt <= (sys_rst || !adcEnable) ? 0 : convCnt + 1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence reqSeen;
    cyc_i && stb_i && !ack_o;
  endsequence
  // Six edges low clears the two sync flops with room to spare
  sequence pinLow;
    !standbyPinN [*6];
  endsequence
  a_ack_follows: assert property (reqSeen |=> ack_o)
    else $error("no ack after request");
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  a_read_width: assert property (ack_o |-> dat_o[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_open_drain: assert property (!overtempOutO)
    else $error("overtemp pin driven high");
  a_standby_halts: assert property (pinLow |-> !adcEnable)
    else $error("converter on in standby");
  a_start_remote: assert property ($rose(adcEnable) |-> !adcChannel)
    else $error("conversion began on local");
  a_conv_bound: assert property (adcEnable |-> convCnt <= 2 * HALF_CYCLES + 1)
    else $error("conversion too long");
  a_local_half: assert property ($rose(adcChannel) |->
      convCnt >= HALF_CYCLES - 2 && convCnt <= HALF_CYCLES + 1)
    else $error("channel switch off mid point");
endmodule // standby_props
bind standby_conversion_control standby_props #(
  .HALF_CYCLES(HALF_CYCLES)
) props_inst (.clk(clk), .sys_rst(sys_rst), .cyc_i(cyc_i), .stb_i(stb_i),
  .dat_o(dat_o), .ack_o(ack_o), .standbyPinN(standbyPinN),
  .overtempOutO(overtempOutO), .adcEnable(adcEnable),
  .adcChannel(adcChannel));
`default_nettype wire

// File: verif/conv_frontend_model.sv
`timescale 1ns/10ps
`default_nettype none
module conv_frontend_model (
  // Clock and control
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic adcEnable,
  // Temperatures to report
  input wire logic [7:0] remoteTemp,
  input wire logic [7:0] localTemp,
  // Samples
  output var logic [7:0] remoteSample,
  output var logic [7:0] localSample
);
  // Idle front end toggles so stale data never looks valid
  always @(posedge clk) begin
    if (sys_rst) begin
      remoteSample <= 8'h5a;
      localSample <= 8'ha5;
    end else begin
      remoteSample <= adcEnable ? remoteTemp : ~remoteSample;
      localSample <= adcEnable ? localTemp : ~localSample;
    end
  end
endmodule // conv_frontend_model
`default_nettype wire

// File: verif/standby_conversion_control_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "standby_ctrl_defs.vh"
module standby_conversion_control_tb;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'hf;
  logic [31:0] dat_i = 32'h0;
  logic standbyPinN = 1'b1;
  logic addrSelect0 = 1'b1;
  logic addrSelect1 = 1'b0;
  logic [7:0] remoteTemp = 8'h10;
  logic [7:0] localTemp = 8'h20;
  wire logic [31:0] dat_o;
  wire logic [7:0] remoteSample, localSample;
  wire logic ack_o, overtempOutO, overtempOutOe, adcEnable, adcChannel;
  // Open drain with pull-up
  wire logic overtempPin = overtempOutOe ? overtempOutO : 1'b1;
  int errors = 0;
  int check_count = 0;
  logic [31:0] rd;
  int gap;
  // Must match the HALF_CYCLES override below
  localparam int HALF = 20;
  standby_conversion_control #(
    .HALF_CYCLES(24'h14)
  ) standby_conversion_control_inst (
    .clk(clk),
    .sys_rst(sys_rst),
    .cyc_i(cyc_i),
    .stb_i(stb_i),
    .we_i(we_i),
    .adr_i(adr_i),
    .sel_i(sel_i),
    .dat_i(dat_i),
    .dat_o(dat_o),
    .ack_o(ack_o),
    .standbyPinN(standbyPinN),
    .addrSelect0(addrSelect0),
    .addrSelect1(addrSelect1),
    .overtempOutI(overtempPin),
    .overtempOutO(overtempOutO),
    .overtempOutOe(overtempOutOe),
    .remoteSample(remoteSample),
    .localSample(localSample),
    .adcEnable(adcEnable),
    .adcChannel(adcChannel)
  );
  conv_frontend_model conv_frontend_model_inst (
    .clk(clk),
    .sys_rst(sys_rst),
    .adcEnable(adcEnable),
    .remoteTemp(remoteTemp),
    .localTemp(localTemp),
    .remoteSample(remoteSample),
    .localSample(localSample)
  );
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic fail(input string m);
    errors++;
    $display("unexpected at %0t: %s", $time, m);
  endtask
  task automatic chk(input logic [31:0] got, exp, input string m);
    check_count++;
    if (got !== exp) fail(m);
  endtask
  task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do @(posedge clk); while (ack_o !== 1'b1 && ++n < 20);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (n >= 20) fail("no ack");
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [31:0] e,
      input string m);
    xfer(1'b0, a, 32'h0);
    chk(rd, e, m);
  endtask
  task automatic waitConv(input logic fin);
    int n;
    n = 0;
    while (adcEnable !== 1'b1 && n++ < 300) @(posedge clk);
    while (fin && adcEnable === 1'b1 && n++ < 300) @(posedge clk);
    if (n >= 300) fail("no conversion");
  endtask
  task automatic settle(input int c, input logic e, input string m);
    repeat (c) @(posedge clk);
    chk(overtempOutOe, e, m);
  endtask
  task automatic tally_and_finish;
    $display("errors=%0d checks=%0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #100000;
    fail("timeout");
    tally_and_finish;
  end
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    rdChk(`OFS_TRIP, 32'h64, "trip reset");
    rdChk(`OFS_RELEASE, 32'h5f, "release reset");
    rdChk(`OFS_CONFIG, 32'h00, "config reset");
    rdChk(8'h20, 32'h00, "unmapped");
    xfer(1'b0, `OFS_STATUS, 32'h0);
    chk(rd & 32'h30, 32'h10, "straps");
    chk(overtempOutOe, 1'b0, "oe reset");
    waitConv(1'b1);
    rdChk(`OFS_REMOTE, 32'h10, "remote");
    rdChk(`OFS_LOCAL, 32'h20, "local");
    xfer(1'b1, `OFS_RATE, 32'h01);
    waitConv(1'b1);
    gap = 0;
    while (adcEnable !== 1'b1 && gap < 300) begin
      @(posedge clk);
      gap++;
    end
    chk(gap, 2 * HALF + 1, "rate gap");
    xfer(1'b1, `OFS_RATE, 32'h00);
    xfer(1'b1, `OFS_CONFIG, 32'h40);
    remoteTemp <= 8'h70;
    localTemp <= 8'h21;
    repeat (100) @(posedge clk);
    chk(adcEnable, 1'b0, "halt");
    rdChk(`OFS_REMOTE, 32'h10, "halted");
    xfer(1'b1, `OFS_ONESHOT, 32'h01);
    waitConv(1'b1);
    rdChk(`OFS_LOCAL, 32'h21, "oneshot");
    chk(overtempOutOe, 1'b1, "trip");
    xfer(1'b0, `OFS_STATUS, 32'h0);
    chk(rd & 32'h42, 32'h02, "trip status");
    xfer(1'b1, `OFS_CONFIG, 32'h60);
    settle(3, 1'b0, "polarity");
    xfer(1'b1, `OFS_CONFIG, 32'h40);
    xfer(1'b1, `OFS_TRIP, 32'h7f);
    settle(3, 1'b1, "hysteresis");
    xfer(1'b1, `OFS_RELEASE, 32'h75);
    settle(3, 1'b0, "new limits");
    xfer(1'b0, `OFS_STATUS, 32'h0);
    chk(rd & 32'h42, 32'h40, "release status");
    standbyPinN <= 1'b0;
    remoteTemp <= 8'h05;
    xfer(1'b1, `OFS_ONESHOT, 32'h01);
    repeat (100) @(posedge clk);
    chk(adcEnable, 1'b0, "hw oneshot");
    xfer(1'b1, `OFS_CONFIG, 32'h00);
    repeat (100) @(posedge clk);
    chk(adcEnable, 1'b0, "hw auto");
    rdChk(`OFS_REMOTE, 32'h70, "hw read");
    standbyPinN <= 1'b1;
    waitConv(1'b0);
    repeat (30) @(posedge clk);
    standbyPinN <= 1'b0;
    repeat (60) @(posedge clk);
    rdChk(`OFS_REMOTE, 32'h70, "hw abort");
    standbyPinN <= 1'b1;
    localTemp <= 8'h33;
    waitConv(1'b0);
    xfer(1'b1, `OFS_CONFIG, 32'h40);
    repeat (60) @(posedge clk);
    rdChk(`OFS_LOCAL, 32'h21, "sw abort");
    rdChk(`OFS_REMOTE, 32'h70, "sw abort remote");
    xfer(1'b1, `OFS_CONFIG, 32'h00);
    waitConv(1'b1);
    rdChk(`OFS_REMOTE, 32'h05, "resume");
    rdChk(`OFS_LOCAL, 32'h33, "resume local");
    tally_and_finish;
  end
endmodule // standby_conversion_control_tb
`default_nettype wire
